// File: include/dir_pkg.sv
// Package with register map, field layout and timing constants.
package dir_pkg;
    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_SERIAL_INPUT_WORD    = 16'hc011;
    localparam logic [15:0] ADDR_REQUEST_PIN_CONTROL  = 16'hc012;
    localparam logic [15:0] ADDR_OUTPUT_RATE_LOW      = 16'hc013;
    localparam logic [15:0] ADDR_OUTPUT_RATE_HIGH_PLL = 16'hc014;
    localparam logic [15:0] ADDR_LEFT_SAMPLE          = 16'hc015;
    localparam logic [15:0] ADDR_RIGHT_SAMPLE         = 16'hc016;
    localparam logic [15:0] ADDR_IRQ_ENABLE_MASK      = 16'hc01a;
    localparam logic [15:0] ADDR_IRQ_GLOBAL_DISABLE   = 16'hc01b;
    localparam logic [15:0] ADDR_IRQ_GLOBAL_ENABLE    = 16'hc01c;
    localparam logic [15:0] ADDR_IRQ_NESTING_COUNT    = 16'hc01d;
    localparam logic [15:0] ADDR_INPUT_SAMPLE_DIVIDER = 16'hc01e;
    localparam logic [15:0] ADDR_INPUT_SAMPLE_VALUE   = 16'hc01f;

    // ------------------------------------------------------------------
    // Field layout and widths
    // ------------------------------------------------------------------
    localparam int          NUM_SRC        = 8;
    localparam int          NEST_W         = 5;
    localparam int          ACC_W          = 26;
    localparam int          INCR_W         = 20;
    localparam int          RATE_HI_LSB    = 0;
    localparam int          RATE_HI_W      = 4;
    localparam int          SRC_AUDIO_OUT  = 0;
    localparam int          SRC_CTRL_PORT  = 1;
    localparam int          SRC_DATA_IN    = 2;
    localparam int          SRC_MODULATOR  = 3;
    localparam int          SRC_SER_TX     = 4;
    localparam int          SRC_SER_RX     = 5;
    localparam int          SRC_TIMER0     = 6;
    localparam int          SRC_TIMER1     = 7;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [1:0]  ACC_STEP_PERIOD = 2'h3;
    localparam int          MOD_CYC_PER_DIV = 128;
    localparam int          ENABLE_LAT_MAX  = 6;
endpackage

// File: design/dir_rate_acc.sv
// Output sample-rate phase accumulator.
`timescale 1ns/1ps
module dir_rate_acc #(
    parameter int ACC_W  = dir_pkg::ACC_W,
    parameter int INCR_W = dir_pkg::INCR_W
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic [INCR_W-1:0] incr,
    output logic                   ovf_pulse
);
    initial begin
        if (INCR_W >= ACC_W) begin
            $error("dir_rate_acc: increment must be narrower than acc");
        end
    end

    logic [1:0]       phase_ff;
    logic [1:0]       nxt_phase;
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic             ovf_ff;
    logic             nxt_ovf;
    logic [ACC_W:0]   sum;

    // The sum is taken once every fourth cycle; the carry is the overflow.
    always_comb begin
        sum       = {1'b0, acc_ff} + {{(ACC_W+1-INCR_W){1'b0}}, incr};
        nxt_phase = phase_ff + 2'h1;
        nxt_acc   = acc_ff;
        nxt_ovf   = 1'b0;
        if (phase_ff == dir_pkg::ACC_STEP_PERIOD) begin
            nxt_acc = sum[ACC_W-1:0];
            nxt_ovf = sum[ACC_W];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase_ff <= 2'h0;
            acc_ff   <= '0;
            ovf_ff   <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            acc_ff   <= nxt_acc;
            ovf_ff   <= nxt_ovf;
        end
    end

    assign ovf_pulse = ovf_ff;
endmodule

// File: design/dir_mod_timer.sv
// Input modulator sample timer: one tick per 128 x divider cycles.
`timescale 1ns/1ps
module dir_mod_timer #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [DIV_W-1:0] divider,
    output logic                  sample_tick
);
    localparam int CNT_W = DIV_W + $clog2(dir_pkg::MOD_CYC_PER_DIV);

    initial begin
        if (DIV_W < 1) begin
            $error("dir_mod_timer: divider width must be positive");
        end
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] period;
    logic             tick_ff;
    logic             nxt_tick;

    always_comb begin
        period   = CNT_W'({divider, {$clog2(dir_pkg::MOD_CYC_PER_DIV){1'b0}}});
        nxt_cnt  = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        nxt_tick = 1'b0;
        if (divider == '0) begin
            // A zero divider holds the modulator off.
            nxt_cnt = '0;
        end else if (cnt_ff >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign sample_tick = tick_ff;
endmodule

// File: design/dir_periph_regs.sv
// Peripheral register slice with nesting interrupt controller.
`timescale 1ns/1ps
module dir_periph_regs #(
    parameter int DATA_W = 16,
    parameter int NSRC   = dir_pkg::NUM_SRC
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Processor register port.
    input  wire logic [15:0]       reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0]      reg_rdata,
    // Core interrupt handshake.
    output logic                   irq_req,
    output logic [NSRC-1:0]        irq_vector,
    input  wire logic              irq_ack,
    // Peripheral event sources.
    input  wire logic [NSRC-1:0]   src_event,
    input  wire logic              serial_byte_valid,
    input  wire logic [7:0]        serial_byte,
    input  wire logic [DATA_W-1:0] adc_result,
    // Output converter side.
    output logic [DATA_W-1:0]      dac_left_out,
    output logic [DATA_W-1:0]      dac_right_out,
    output logic                   dac_load,
    output logic [DATA_W-1:0]      pll_control,
    output logic                   data_request_pin,
    output logic                   adc_sample_tick
);
    initial begin
        if (DATA_W != 16 || NSRC != dir_pkg::NUM_SRC) begin
            $error("dir_periph_regs: unsupported width or source count");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]            ser_word_ff,  nxt_ser_word;
    logic                         data_request_pin_ff,      nxt_data_request_pin;
    logic [DATA_W-1:0]            rate_lo_ff,   nxt_rate_lo;
    logic [DATA_W-1:0]            rate_hi_ff,   nxt_rate_hi;
    logic [DATA_W-1:0]            left_ff,      nxt_left;
    logic [DATA_W-1:0]            right_ff,     nxt_right;
    logic [NSRC-1:0]              mask_ff,      nxt_mask;
    logic [dir_pkg::NEST_W-1:0]   nest_ff,      nxt_nest;
    logic [DATA_W-1:0]            adiv_ff,      nxt_adiv;
    logic [DATA_W-1:0]            adata_ff,     nxt_adata;
    logic [NSRC-1:0]              pend_ff,      nxt_pend;
    logic [DATA_W-1:0]            dacl_ff,      nxt_dacl;
    logic [DATA_W-1:0]            dacr_ff,      nxt_dacr;
    logic                         dload_ff,     nxt_dload;
    logic [DATA_W-1:0]            rdata_ff,     nxt_rdata;
    logic [NSRC-1:0]              vec_ff,       nxt_vec;
    logic                         req_ff,       nxt_req;

    logic                         acc_ovf;
    logic                         mod_tick;
    logic [dir_pkg::INCR_W-1:0]   rate_incr;
    logic [NSRC-1:0]              events;
    logic [NSRC-1:0]              eligible;
    logic [NSRC-1:0]              take_sel;

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    assign rate_incr = {rate_hi_ff[dir_pkg::RATE_HI_LSB +: dir_pkg::RATE_HI_W],
                        rate_lo_ff};

    dir_rate_acc #(
        .ACC_W  (dir_pkg::ACC_W),
        .INCR_W (dir_pkg::INCR_W)
    ) u_rate_acc (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .incr      (rate_incr),
        .ovf_pulse (acc_ovf)
    );

    dir_mod_timer #(
        .DIV_W (DATA_W)
    ) u_mod_timer (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .divider     (adiv_ff),
        .sample_tick (mod_tick)
    );

    // ------------------------------------------------------------------
    // Interrupt sources and priority
    // ------------------------------------------------------------------
    always_comb begin
        events = src_event;
        events[dir_pkg::SRC_AUDIO_OUT] = src_event[dir_pkg::SRC_AUDIO_OUT]
                                         | acc_ovf;
        events[dir_pkg::SRC_MODULATOR] = src_event[dir_pkg::SRC_MODULATOR]
                                         | mod_tick;
        // Registered mask and counter keep the effect within six cycles.
        eligible = pend_ff & mask_ff;
        take_sel = '0;
        // Lowest bit wins when several sources are pending.
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                take_sel = '0;
                take_sel[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ser_word = ser_word_ff;
        nxt_data_request_pin     = data_request_pin_ff;
        nxt_rate_lo  = rate_lo_ff;
        nxt_rate_hi  = rate_hi_ff;
        nxt_left     = left_ff;
        nxt_right    = right_ff;
        nxt_mask     = mask_ff;
        nxt_nest     = nest_ff;
        nxt_adiv     = adiv_ff;
        nxt_adata    = adata_ff;
        nxt_dacl     = dacl_ff;
        nxt_dacr     = dacr_ff;
        nxt_dload    = acc_ovf;
        nxt_rdata    = rdata_ff;
        nxt_pend     = pend_ff;
        nxt_vec      = vec_ff;
        nxt_req      = 1'b0;

        if (serial_byte_valid) begin
            nxt_ser_word = {ser_word_ff[7:0], serial_byte};
        end
        if (acc_ovf) begin
            nxt_dacl = left_ff;
            nxt_dacr = right_ff;
        end
        if (mod_tick) begin
            nxt_adata = adc_result;
        end

        if (reg_wr) begin
            case (reg_addr)
                dir_pkg::ADDR_REQUEST_PIN_CONTROL:  nxt_data_request_pin = reg_wdata[0];
                dir_pkg::ADDR_OUTPUT_RATE_LOW: begin
                    nxt_rate_lo = reg_wdata;
                end
                dir_pkg::ADDR_OUTPUT_RATE_HIGH_PLL: begin
                    nxt_rate_hi = reg_wdata;
                end
                dir_pkg::ADDR_LEFT_SAMPLE:   nxt_left  = reg_wdata;
                dir_pkg::ADDR_RIGHT_SAMPLE:  nxt_right = reg_wdata;
                dir_pkg::ADDR_IRQ_ENABLE_MASK: begin
                    nxt_mask = reg_wdata[NSRC-1:0];
                end
                dir_pkg::ADDR_IRQ_GLOBAL_DISABLE: begin
                    nxt_nest = nest_ff + 5'h01;
                end
                dir_pkg::ADDR_IRQ_GLOBAL_ENABLE: begin
                    if (nest_ff != '0) begin
                        nxt_nest = nest_ff - 5'h01;
                    end
                end
                dir_pkg::ADDR_IRQ_NESTING_COUNT: begin
                    nxt_nest = reg_wdata[dir_pkg::NEST_W-1:0];
                end
                dir_pkg::ADDR_INPUT_SAMPLE_DIVIDER: nxt_adiv = reg_wdata;
                dir_pkg::ADDR_INPUT_SAMPLE_VALUE: begin
                    nxt_adata = reg_wdata;
                end
                default: ;
            endcase
        end

        // Request is offered only while the counter is zero.
        if (nest_ff == '0 && eligible != '0 && !req_ff) begin
            nxt_req = 1'b1;
            nxt_vec = take_sel;
        end else if (req_ff && !irq_ack) begin
            // Drop the request once its source is masked off.
            nxt_req = nest_ff == '0 && (vec_ff & eligible) != '0;
        end
        if (req_ff && irq_ack) begin
            nxt_pend = pend_ff & ~vec_ff;
            nxt_nest = nxt_nest + 5'h01;
        end
        // A new event wins over the clear of the same flag.
        nxt_pend = nxt_pend | events;

        if (reg_rd) begin
            case (reg_addr)
                dir_pkg::ADDR_SERIAL_INPUT_WORD: begin
                    nxt_rdata = ser_word_ff;
                end
                dir_pkg::ADDR_OUTPUT_RATE_LOW:      nxt_rdata = rate_lo_ff;
                dir_pkg::ADDR_OUTPUT_RATE_HIGH_PLL: nxt_rdata = rate_hi_ff;
                dir_pkg::ADDR_LEFT_SAMPLE:          nxt_rdata = left_ff;
                dir_pkg::ADDR_RIGHT_SAMPLE:         nxt_rdata = right_ff;
                dir_pkg::ADDR_IRQ_ENABLE_MASK: begin
                    nxt_rdata = {{(DATA_W-NSRC){1'b0}}, mask_ff};
                end
                dir_pkg::ADDR_IRQ_NESTING_COUNT: begin
                    nxt_rdata = {{(DATA_W-dir_pkg::NEST_W){1'b0}}, nest_ff};
                end
                dir_pkg::ADDR_INPUT_SAMPLE_DIVIDER: nxt_rdata = adiv_ff;
                dir_pkg::ADDR_INPUT_SAMPLE_VALUE:   nxt_rdata = adata_ff;
                default:                            nxt_rdata = dir_pkg::RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ser_word_ff <= dir_pkg::RST_WORD;
            data_request_pin_ff     <= 1'b0;
            rate_lo_ff  <= dir_pkg::RST_WORD;
            rate_hi_ff  <= dir_pkg::RST_WORD;
            left_ff     <= dir_pkg::RST_WORD;
            right_ff    <= dir_pkg::RST_WORD;
            mask_ff     <= '0;
            nest_ff     <= '0;
            adiv_ff     <= dir_pkg::RST_WORD;
            adata_ff    <= dir_pkg::RST_WORD;
            pend_ff     <= '0;
            dacl_ff     <= dir_pkg::RST_WORD;
            dacr_ff     <= dir_pkg::RST_WORD;
            dload_ff    <= 1'b0;
            rdata_ff    <= dir_pkg::RST_WORD;
            vec_ff      <= '0;
            req_ff      <= 1'b0;
        end else begin
            ser_word_ff <= nxt_ser_word;
            data_request_pin_ff     <= nxt_data_request_pin;
            rate_lo_ff  <= nxt_rate_lo;
            rate_hi_ff  <= nxt_rate_hi;
            left_ff     <= nxt_left;
            right_ff    <= nxt_right;
            mask_ff     <= nxt_mask;
            nest_ff     <= nxt_nest;
            adiv_ff     <= nxt_adiv;
            adata_ff    <= nxt_adata;
            pend_ff     <= nxt_pend;
            dacl_ff     <= nxt_dacl;
            dacr_ff     <= nxt_dacr;
            dload_ff    <= nxt_dload;
            rdata_ff    <= nxt_rdata;
            vec_ff      <= nxt_vec;
            req_ff      <= nxt_req;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata        = rdata_ff;
    assign irq_req          = req_ff;
    assign irq_vector       = vec_ff;
    assign dac_left_out     = dacl_ff;
    assign dac_right_out    = dacr_ff;
    assign dac_load         = dload_ff;
    assign pll_control      = rate_hi_ff;
    assign data_request_pin = data_request_pin_ff;
    assign adc_sample_tick  = mod_tick;
endmodule

// File: tb/dir_core_model.sv
// Behavioural model of the processor core taking interrupts.
`timescale 1ns/1ps
module dir_core_model (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector,
    input  wire logic       ack_on,
    output logic            irq_ack,
    output logic [7:0]      last_vec
);
    int wait_cnt = 0;
    initial begin
        irq_ack = 1'b0;
        last_vec = 8'h00;
    end
    // The ack is a one-cycle pulse, raised only after a short wait.
    always @(posedge clk_sys) begin
        if (irq_ack === 1'b1 && irq_req === 1'b1) begin
            last_vec <= irq_vector;
        end
        #1;
        irq_ack = 1'b0;
        if (sys_rst === 1'b0 && ack_on && irq_req === 1'b1) begin
            wait_cnt++;
            if (wait_cnt > 1) begin
                irq_ack = 1'b1;
                wait_cnt = 0;
            end
        end else begin
            wait_cnt = 0;
        end
    end
endmodule

// File: tb/dir_periph_regs_chk.sv
// Checker of the peripheral register slice port behaviour.
`timescale 1ns/1ps
module dir_periph_regs_chk (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        irq_req,
    input wire logic [7:0]  irq_vector,
    input wire logic        irq_ack,
    input wire logic [15:0] dac_left_out,
    input wire logic        dac_load,
    input wire logic [15:0] pll_control
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // Shadow of mask and nesting count, and cycles since one of them was last written
    // ------------------------------------------------------------------
    logic [7:0] msk_ff;
    logic [4:0] nst_ff;
    logic [2:0] qt_ff;
    logic       w_m;
    logic       w_d;
    logic       w_e;
    logic       w_c;
    logic       tk;
    assign w_m = reg_wr && reg_addr == dir_pkg::ADDR_IRQ_ENABLE_MASK;
    assign w_d = reg_wr && reg_addr == dir_pkg::ADDR_IRQ_GLOBAL_DISABLE;
    assign w_e = reg_wr && reg_addr == dir_pkg::ADDR_IRQ_GLOBAL_ENABLE;
    assign w_c = reg_wr && reg_addr == dir_pkg::ADDR_IRQ_NESTING_COUNT;
    assign tk = irq_ack && irq_req;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            msk_ff <= 8'h00;
            nst_ff <= 5'h00;
            qt_ff <= 3'h0;
        end else begin
            if (w_m)
                msk_ff <= reg_wdata[7:0];
            if (w_c)
                nst_ff <= reg_wdata[4:0] + 5'(tk);
            else
                nst_ff <= nst_ff + 5'(w_d) + 5'(tk)
                          - 5'(w_e && nst_ff != 5'h00);
            if (w_m || w_d || w_e || w_c)
                qt_ff <= 3'h0;
            else
                qt_ff <= qt_ff + 3'(qt_ff != 3'h7);
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_vec_onehot: assert property (irq_req |-> $onehot(irq_vector))
        else $error("irq vector not one-hot");
    a_ack_drops_req: assert property (tk |=> !irq_req)
        else $error("request stayed up after ack");
    a_dis_blocks: assert property (w_d |=> ##[0:5] !irq_req)
        else $error("request not blocked after global disable");
    a_req_gated: assert property (irq_req && qt_ff >= 3'h6 |->
        nst_ff == 5'h00 && (irq_vector & msk_ff) != 8'h00)
        else $error("request without mask bit or with count nonzero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_dac_on_load: assert property (!$stable(dac_left_out) |-> dac_load)
        else $error("left output changed without load pulse");
    a_load_spacing: assert property (dac_load |=> !dac_load [*3])
        else $error("load pulses closer than four cycles");
    a_pll_copy: assert property (reg_wr &&
        reg_addr == dir_pkg::ADDR_OUTPUT_RATE_HIGH_PLL
        |=> pll_control == $past(reg_wdata))
        else $error("pll control not taken from high rate write");
endmodule

// File: tb/tb.sv
// Testbench for the peripheral register slice.
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [7:0]  src_event = 8'h00;
    logic        serial_byte_valid = 1'b0;
    logic [7:0]  serial_byte = 8'h00;
    logic [15:0] adc_result = 16'h1234;
    logic        ack_on = 1'b1;
    logic [15:0] reg_rdata, dac_left_out, dac_right_out, pll_control;
    logic [7:0]  irq_vector, last_vec;
    logic        irq_req, irq_ack, dac_load, data_request_pin, adc_sample_tick;
    int          mismatches = 0, cmp_count = 0, cycles = 0, c;
    logic [15:0] wa [6] = '{16'hc013, 16'hc014, 16'hc015, 16'hc016,
                            16'hc01a, 16'hc01d};
    logic [15:0] wm [6] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff,
                            16'h00ff, 16'h001f};
    always #5 clk_sys = ~clk_sys;
    dir_periph_regs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_ack(irq_ack), .src_event(src_event),
        .serial_byte_valid(serial_byte_valid), .serial_byte(serial_byte),
        .adc_result(adc_result), .dac_left_out(dac_left_out),
        .dac_right_out(dac_right_out), .dac_load(dac_load),
        .pll_control(pll_control), .data_request_pin(data_request_pin),
        .adc_sample_tick(adc_sample_tick));
    dir_core_model u_core (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .irq_req(irq_req), .irq_vector(irq_vector), .ack_on(ack_on),
        .irq_ack(irq_ack), .last_vec(last_vec));
    // ------------------------------------------------------------------
    // Bus and check tasks; every drive happens 1 ns after a rising edge
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk($sformatf("reg %h", a), reg_rdata, e);
    endtask
    task automatic pulse(input logic [7:0] ev, input logic v,
                         input logic [7:0] b);
        tick(1);
        src_event = ev;
        serial_byte_valid = v;
        serial_byte = b;
        tick(1);
        src_event = 8'h00;
        serial_byte_valid = 1'b0;
    endtask
    // Counts cycles until the selected output is seen high, up to lim.
    task automatic wait_sig(input int sel, input int lim, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (n < lim && (sel == 0 ? dac_load : sel == 1 ?
                   adc_sample_tick : irq_req) !== 1'b1);
    endtask
    task automatic take(input logic [7:0] v);
        wait_sig(2, 20, c);
        tick(4);
        chk("vector", {8'h00, last_vec}, {8'h00, v});
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 15; i++)
            rd(16'hc011 + 16'(i), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            wr(wa[i], 16'h5aa5);
            rd(wa[i], 16'h5aa5 & wm[i]);
        end
        wr(16'hc01d, 16'h0000);
        wr(16'hc01a, 16'h0000);
        wr(16'hc01e, 16'h5aa5);
        rd(16'hc01e, 16'h5aa5);
        wr(16'hc01e, 16'h0000);
        wr(16'hc012, 16'h0001);
        chk("request pin", {15'h0, data_request_pin}, 16'h0001);
        wr(16'hc011, 16'hffff);
        rd(16'hc011, 16'h0000);
        pulse(8'h00, 1'b1, 8'h12);
        pulse(8'h00, 1'b1, 8'h34);
        pulse(8'h00, 1'b1, 8'h56);
        rd(16'hc011, 16'h3456);
        wr(16'hc013, 16'h0000);
        wr(16'hc015, 16'h1111);
        wr(16'hc016, 16'h2222);
        wr(16'hc014, 16'h00a8);
        chk("pll", pll_control, 16'h00a8);
        wait_sig(0, 2000, c);
        wait_sig(0, 2000, c);
        chk("load period", 16'(c), 16'd512);
        chk("left out", dac_left_out, 16'h1111);
        chk("right out", dac_right_out, 16'h2222);
        wr(16'hc01a, 16'h0001);
        take(8'h01);
        wr(16'hc014, 16'h0000);
        wr(16'hc01c, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(16'hc01a, 16'(1 << i));
            pulse(8'(1 << i), 1'b0, 8'h00);
            take(8'(1 << i));
            rd(16'hc01d, 16'h0001);
            wr(16'hc01c, 16'h0000);
        end
        pulse(8'h80, 1'b0, 8'h00);
        take(8'h80);
        pulse(8'h80, 1'b0, 8'h00);
        tick(10);
        chk("blocked", {15'h0, irq_req}, 16'h0000);
        wr(16'hc01c, 16'h0000);
        take(8'h80);
        wr(16'hc01c, 16'h0000);
        wr(16'hc01a, 16'h0000);
        pulse(8'h08, 1'b0, 8'h00);
        tick(10);
        chk("masked", {15'h0, irq_req}, 16'h0000);
        wr(16'hc01a, 16'h0082);
        wait_sig(2, 8, c);
        chk("stale", {15'h0, irq_req}, 16'h0000);
        wr(16'hc01a, 16'h0008);
        wait_sig(2, 8, c);
        chk("mask on", {15'h0, irq_req}, 16'h0001);
        tick(4);
        wr(16'hc01c, 16'h0000);
        wr(16'hc01a, 16'h0082);
        pulse(8'h82, 1'b0, 8'h00);
        take(8'h02);
        wr(16'hc01c, 16'h0000);
        take(8'h80);
        wr(16'hc01c, 16'h0000);
        wr(16'hc01b, 16'h1234);
        wr(16'hc01b, 16'h0000);
        rd(16'hc01d, 16'h0002);
        for (int i = 0; i < 3; i++)
            wr(16'hc01c, 16'hffff);
        rd(16'hc01d, 16'h0000);
        ack_on = 1'b0;
        pulse(8'h80, 1'b0, 8'h00);
        wait_sig(2, 20, c);
        wr(16'hc01b, 16'h0000);
        tick(6);
        chk("disabled", {15'h0, irq_req}, 16'h0000);
        wr(16'hc01c, 16'h0000);
        wait_sig(2, 8, c);
        chk("restored", {15'h0, irq_req}, 16'h0001);
        wr(16'hc01a, 16'h0000);
        tick(6);
        chk("unmasked", {15'h0, irq_req}, 16'h0000);
        wr(16'hc01a, 16'h0080);
        ack_on = 1'b1;
        tick(4);
        wr(16'hc01c, 16'h0000);
        rd(16'hc01d, 16'h0000);
        wr(16'hc01a, 16'h0000);
        wr(16'hc01e, 16'h0004);
        wait_sig(1, 2000, c);
        wait_sig(1, 2000, c);
        chk("sample period", 16'(c), 16'd512);
        rd(16'hc01f, 16'h1234);
        adc_result = 16'h0bcd;
        wait_sig(1, 600, c);
        rd(16'hc01f, 16'h0bcd);
        wr(16'hc01e, 16'h0000);
        wait_sig(1, 1200, c);
        chk("off", 16'(c), 16'd1200);
        end_of_test();
    end
endmodule
bind dir_periph_regs dir_periph_regs_chk u_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .dac_left_out(dac_left_out), .dac_load(dac_load),
    .pll_control(pll_control));
